/* File: ldc_top.sv */
// link delay accounting, round-trip measurement and single-trip calibration
//
// Behaviour
// RL1: tx path delay spans frame first bit at aux input to serial link start.
// RL2: tx elastic buffer delay, clock phase included, is a measured variable term.
// RL3: tx bitslip delay is added only in the radio-equipment slave role.
// RL4: masters measure round-trip delay from internal tx frame to rx frame start.
// RL5: software reads round-trip value periodically, checks drift within 16.276 ns.
// RL6: multi-hop total sums hops and routers, minus all but final loopback.
// RL7: single-trip calibration acts only while the enable bit is set.
// RL8: software programs target as whole cycles plus fractional steps.
// RL9: slave reports measured single-trip variable delay in a status field.
// RL10: consistency check runs on manual request or once per hyperframe.
// RL11: after each check the receive delay moves toward the target.
// RL12: receive delay moves by shifting core clock phase, not adding stages.
// RL13: measured single-trip delay uses the master's supplied tx delay.
// RL14: master selects hyperframe insertion or system register write of tx delay.
// RL15: slave selects hyperframe extraction or its own register for tx delay.
// RL16: software programs matching selections and positions at both ends.
// RL17: a foreign master must deliver a correct tx delay where slave expects.
// RL18: software may write an application-chosen tx delay instead.
// RL19: phase unit link is a two-bit status input and sixteen-bit control.
// RL20: too long shortens receive delay, too short lengthens it, equal holds.
`timescale 1ns/1ps
`default_nettype none
module ldc_top #(
	parameter int FRAME_CYCLES = ldc_pkg::FRAME_CYCLES
) (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	// apb slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [ldc_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [ldc_pkg::DATA_W-1:0]  pwdata,
	output var  logic [ldc_pkg::DATA_W-1:0]  prdata,
	output var  logic                        pready,
	output var  logic                        pslverr,
	// core role
	input  wire logic                        role_master,
	input  wire logic                        role_re_slave,
	// tx path delay terms
	input  wire logic [ldc_pkg::DELAY_W-1:0] txbuf_delay,
	input  wire logic [ldc_pkg::DELAY_W-1:0] tx_slip_delay,
	// radio frame access points
	input  wire logic                        tx_frame_start,
	input  wire logic                        rx_frame_start,
	// hyperframe control word slots
	input  wire logic                        hf_start,
	input  wire logic                        bf_strobe,
	input  wire logic [ldc_pkg::POS_W-1:0]   hf_index,
	input  wire logic [ldc_pkg::BYTE_W-1:0]  cw_rx_byte,
	output var  logic [ldc_pkg::BYTE_W-1:0]  cw_tx_byte,
	output var  logic                        cw_tx_valid,
	// slave local receive variable delay
	input  wire logic [ldc_pkg::DELAY_W-1:0] rx_var_delay,
	// phase control unit
	input  wire logic [ldc_pkg::STAT_W-1:0]  cal_status,
	output var  logic [ldc_pkg::CTRL_W-1:0]  cal_ctrl
);
	import ldc_pkg::*;

	// ************************************************
	// registers
	// ************************************************
	logic               cal_en_q;
	logic               auto_hf_q;
	logic               check_q;
	logic [DELAY_W-1:0] target_q;
	logic               slv_hf_q;
	logic [POS_W-1:0]   slv_pos_q;
	logic               mst_hf_q;
	logic [POS_W-1:0]   mst_pos_q;
	logic [DELAY_W-1:0] wr_mtx_q;
	logic [DELAY_W-1:0] mtx_rx_q;
	logic [DELAY_W-1:0] mtx_asm_q;
	logic [DELAY_W-1:0] tx_delay_q;
	logic [DELAY_W-1:0] st_meas_q;
	logic [RTD_W-1:0]   rtd_cnt_q;
	logic               rtd_run_q;
	logic [RTD_W-1:0]   rtd_q;
	logic               rtd_valid_q;
	logic [STAT_W-1:0]  status_s;
	logic               busy;

	// ************************************************
	// apb decode
	// ************************************************
	wire setup     = psel && !penable;
	wire access    = psel && penable && pready;
	wire wr_en     = access && pwrite;
	wire hit_ctrl  = paddr == OFS_ST_CTRL_A;
	wire hit_tgt   = paddr == OFS_ST_TARGET;
	wire hit_slv   = paddr == OFS_SLV_SEL;
	wire hit_mst   = paddr == OFS_MST_SEL;
	wire hit_wmtx  = paddr == OFS_WR_MTX;
	wire hit_stat  = paddr == OFS_ST_STATUS;
	wire hit_rtd   = paddr == OFS_RTD;
	wire hit_txd   = paddr == OFS_TX_DELAY;
	wire hit_any   = hit_ctrl || hit_tgt || hit_slv || hit_mst || hit_wmtx || hit_stat || hit_rtd || hit_txd;
	wire wr_ctrl   = wr_en && hit_ctrl;
	wire wr_tgt    = wr_en && hit_tgt;
	wire wr_slv    = wr_en && hit_slv;
	wire wr_mst    = wr_en && hit_mst;
	wire wr_wmtx   = wr_en && hit_wmtx;

	wire [DATA_W-1:0] rd_ctrl = {29'h0, 1'b0, auto_hf_q, cal_en_q};
	wire [DATA_W-1:0] rd_tgt  = {8'h00, target_q};
	wire [DATA_W-1:0] rd_slv  = {16'h0000, slv_pos_q, 7'h00, slv_hf_q};
	wire [DATA_W-1:0] rd_mst  = {16'h0000, mst_pos_q, 7'h00, mst_hf_q};
	wire [DATA_W-1:0] rd_wmtx = {8'h00, wr_mtx_q};
	wire [DATA_W-1:0] rd_stat = {5'h00, busy, status_s, st_meas_q};
	wire [DATA_W-1:0] rd_rtd  = {rtd_valid_q, 10'h000, rtd_q};
	wire [DATA_W-1:0] rd_txd  = {8'h00, tx_delay_q};

	wire [DATA_W-1:0] rd_mux =
		hit_ctrl ? rd_ctrl :
		hit_tgt  ? rd_tgt  :
		hit_slv  ? rd_slv  :
		hit_mst  ? rd_mst  :
		hit_wmtx ? rd_wmtx :
		hit_stat ? rd_stat :
		hit_rtd  ? rd_rtd  :
		hit_txd  ? rd_txd  : 32'h00000000;

	// ready rises one edge after setup, so every access has no wait state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			prdata  <= setup && !pwrite ? rd_mux : '0;
			pslverr <= setup && !hit_any;
		end
	end

	// ************************************************
	// control registers
	// ************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cal_en_q  <= 1'b0;
			auto_hf_q <= 1'b0;
		end else if (wr_ctrl) begin
			cal_en_q  <= pwdata[BIT_CAL_EN]; // RL7
			auto_hf_q <= pwdata[BIT_AUTO_HF];
		end
	end

	// manual check is a write pulse, not stored
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			check_q <= 1'b0;
		else
			check_q <= (wr_ctrl && pwdata[BIT_CHECK]) || (auto_hf_q && hf_start); // RL10
	end

	// whole cycles above fractional steps
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			target_q <= RST_DELAY;
		else if (wr_tgt)
			target_q <= pwdata[DELAY_W-1:0]; // RL8
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slv_hf_q  <= 1'b0;
			slv_pos_q <= RST_POS;
		end else if (wr_slv) begin
			slv_hf_q  <= pwdata[BIT_SEL_HF]; // RL15
			slv_pos_q <= pwdata[POS_LSB +: POS_W];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mst_hf_q  <= 1'b0;
			mst_pos_q <= RST_POS;
		end else if (wr_mst) begin
			mst_hf_q  <= pwdata[BIT_SEL_HF]; // RL14
			mst_pos_q <= pwdata[POS_LSB +: POS_W];
		end
	end

	// system-written or application-chosen master tx delay
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			wr_mtx_q <= RST_DELAY;
		else if (wr_wmtx)
			wr_mtx_q <= pwdata[DELAY_W-1:0]; // RL18
	end

	// ************************************************
	// tx path delay
	// ************************************************
	wire [DELAY_W-1:0] slip_term = role_re_slave ? tx_slip_delay : RST_DELAY; // RL3
	wire [DELAY_W-1:0] tx_delay_d = DELAY_W'(TX_FIXED_DLY + txbuf_delay + slip_term); // RL2

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			tx_delay_q <= RST_DELAY;
		else
			tx_delay_q <= tx_delay_d; // RL1
	end

	// ************************************************
	// round-trip measurement
	// ************************************************
	wire rtd_limit = rtd_cnt_q == RTD_W'(FRAME_CYCLES - 1);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rtd_cnt_q <= '0;
			rtd_run_q <= 1'b0;
		end else if (role_master && tx_frame_start) begin
			rtd_cnt_q <= '0;
			rtd_run_q <= 1'b1;
		end else if (rtd_run_q && (rx_frame_start || rtd_limit)) begin
			rtd_run_q <= 1'b0;
		end else if (rtd_run_q) begin
			rtd_cnt_q <= RTD_W'(rtd_cnt_q + 1'b1);
		end
	end

	// sap to sap in core clock cycles
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rtd_q       <= '0;
			rtd_valid_q <= 1'b0;
		end else if (!role_master) begin
			rtd_valid_q <= 1'b0;
		end else if (rtd_run_q && rx_frame_start) begin
			rtd_q       <= rtd_cnt_q; // RL4
			rtd_valid_q <= 1'b1;
		end
	end

	// ************************************************
	// hyperframe transport of the master tx delay
	// ************************************************
	wire [POS_W-1:0] mst_off = POS_W'(hf_index - mst_pos_q);
	wire [POS_W-1:0] slv_off = POS_W'(hf_index - slv_pos_q);
	wire mst_slot = role_master && mst_hf_q && bf_strobe && mst_off < POS_W'(HF_BYTES);
	wire slv_slot = !role_master && slv_hf_q && bf_strobe && slv_off < POS_W'(HF_BYTES);
	wire slv_last = slv_slot && slv_off == POS_W'(HF_BYTES - 2'h1);
	wire [BYTE_W-1:0] tx_sel_byte = tx_delay_q[mst_off[1:0]*BYTE_W +: BYTE_W];

	// least significant byte first from the programmed position
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cw_tx_byte  <= '0;
			cw_tx_valid <= 1'b0;
		end else begin
			cw_tx_byte  <= mst_slot ? tx_sel_byte : '0; // RL14
			cw_tx_valid <= mst_slot;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			mtx_asm_q <= RST_DELAY;
		else if (slv_slot)
			mtx_asm_q[slv_off[1:0]*BYTE_W +: BYTE_W] <= cw_rx_byte; // RL15
	end

	// commit only a complete value so a half-received one is never used
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			mtx_rx_q <= RST_DELAY;
		else if (slv_last)
			mtx_rx_q <= {cw_rx_byte, mtx_asm_q[2*BYTE_W-1:0]}; // RL17
	end

	// ************************************************
	// single-trip measurement and calibration
	// ************************************************
	wire [DELAY_W-1:0] mtx_sel   = slv_hf_q ? mtx_rx_q : wr_mtx_q; // RL15
	wire [DELAY_W-1:0] st_meas_d = DELAY_W'(mtx_sel + rx_var_delay); // RL13

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			st_meas_q <= RST_DELAY;
		else
			st_meas_q <= st_meas_d; // RL9
	end

	ldc_sync #(
		.W(STAT_W)
	) u_status_sync (
		.clk  (clk),
		.rst_b(rst_b),
		.din  (cal_status), // RL19
		.dout (status_s)
	);

	ldc_phase_step u_phase (
		.clk     (clk),
		.rst_b   (rst_b),
		.en      (cal_en_q && !role_master), // RL7
		.check   (check_q), // RL11
		.measured(st_meas_q),
		.target  (target_q),
		.status_s(status_s),
		.cal_ctrl(cal_ctrl), // RL19
		.busy    (busy)
	);
endmodule
`default_nettype wire

/* File: ldc_pkg.sv */
// shared constants for the link delay calibration block
`default_nettype none
package ldc_pkg;
	// ************************************************
	// widths
	// ************************************************
	localparam int DATA_W   = 32;
	localparam int ADDR_W   = 8;
	localparam int FRAC_W   = 8;
	localparam int CYC_W    = 16;
	localparam int DELAY_W  = CYC_W + FRAC_W;
	localparam int POS_W    = 8;
	localparam int RTD_W    = 21;
	localparam int CTRL_W   = 16;
	localparam int STAT_W   = 2;
	localparam int BYTE_W   = 8;

	// ************************************************
	// register offsets
	// ************************************************
	localparam logic [ADDR_W-1:0] OFS_ST_CTRL_A = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_ST_TARGET = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SLV_SEL   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_MST_SEL   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_WR_MTX    = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_ST_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_RTD       = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_TX_DELAY  = 8'h1c;

	// ************************************************
	// field positions
	// ************************************************
	localparam int BIT_CAL_EN    = 0;
	localparam int BIT_AUTO_HF   = 1;
	localparam int BIT_CHECK     = 2;
	localparam int BIT_SEL_HF    = 0;
	localparam int POS_LSB       = 8;
	localparam int BIT_RTD_VALID = 31;
	localparam int STAT_BUSY_LSB = 24;
	localparam int CTRL_REQ      = 15;
	localparam int CTRL_DIR      = 14;
	localparam int STS_ACK       = 0;
	localparam int STS_DONE      = 1;

	// ************************************************
	// reset values and fixed figures
	// ************************************************
	localparam logic [DELAY_W-1:0] RST_DELAY    = 24'h000000;
	localparam logic [POS_W-1:0]   RST_POS      = 8'h00;
	localparam logic [DELAY_W-1:0] TX_FIXED_DLY = 24'h000400;
	localparam logic [13:0]        PHASE_STEPS  = 14'h0001;
	localparam logic [1:0]         HF_BYTES     = 2'h3;
	localparam int FRAME_TIME_US = 10000;
	localparam int CLK_MHZ       = 125;
	localparam int FRAME_CYCLES  = FRAME_TIME_US * CLK_MHZ;

	typedef enum logic [2:0] {
		LDC_IDLE = 3'b001,
		LDC_REQ  = 3'b010,
		LDC_WAIT = 3'b100
	} ldc_phase_state_type;
endpackage
`default_nettype wire

/* File: ldc_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ldc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// data
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* File: ldc_phase_step.sv */
// phase shift request sequencer toward the external phase control unit
`timescale 1ns/1ps
`default_nettype none
module ldc_phase_step (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	// control
	input  wire logic                        en,
	input  wire logic                        check,
	input  wire logic [ldc_pkg::DELAY_W-1:0] measured,
	input  wire logic [ldc_pkg::DELAY_W-1:0] target,
	// phase control unit
	input  wire logic [ldc_pkg::STAT_W-1:0]  status_s,
	output var  logic [ldc_pkg::CTRL_W-1:0]  cal_ctrl,
	// state
	output var  logic                        busy
);
	import ldc_pkg::*;

	ldc_phase_state_type state_q;
	ldc_phase_state_type state_d;
	logic dir_q;
	logic dir_d;
	wire  too_long  = measured > target;
	wire  too_short = measured < target;
	wire  start     = en && check && (too_long || too_short);

	always_comb begin
		state_d = state_q;
		dir_d   = dir_q;
		case (state_q)
			LDC_IDLE: begin
				if (start) begin
					// 1 lengthens the receive delay, 0 shortens it
					dir_d   = too_short; // RL20
					state_d = LDC_REQ;
				end
			end
			LDC_REQ: begin
				if (!en)
					state_d = LDC_IDLE;
				else if (status_s[STS_ACK])
					state_d = LDC_WAIT;
			end
			LDC_WAIT: begin
				if (status_s[STS_DONE] && !status_s[STS_ACK])
					state_d = LDC_IDLE;
			end
			default: state_d = LDC_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q  <= LDC_IDLE;
			dir_q    <= 1'b0;
			cal_ctrl <= '0;
			busy     <= 1'b0;
		end else begin
			state_q  <= state_d;
			dir_q    <= dir_d;
			// shift the core clock phase, no pipeline stages added
			cal_ctrl <= (state_d == LDC_REQ) ? {1'b1, dir_d, PHASE_STEPS} : '0; // RL12
			busy     <= state_d != LDC_IDLE;
		end
	end
endmodule
`default_nettype wire

/* File: ldc_top_assertions.sv */
// concurrent checks on the ports of the link delay calibration block
`timescale 1ns/1ps
`default_nettype none
module ldc_chk (
	// clock and reset
	input wire logic                        clk,
	input wire logic                        rst_b,
	// apb
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [ldc_pkg::ADDR_W-1:0]  paddr,
	input wire logic [ldc_pkg::DATA_W-1:0]  prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	// role and delay terms
	input wire logic                        role_master,
	input wire logic                        role_re_slave,
	input wire logic [ldc_pkg::DELAY_W-1:0] txbuf_delay,
	input wire logic [ldc_pkg::DELAY_W-1:0] tx_slip_delay,
	// slots and phase unit
	input wire logic                        bf_strobe,
	input wire logic                        cw_tx_valid,
	input wire logic [ldc_pkg::STAT_W-1:0]  cal_status,
	input wire logic [ldc_pkg::CTRL_W-1:0]  cal_ctrl
);
	import ldc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ************************************************
	// properties
	// ************************************************
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_err_unmapped: assert property (pready && paddr >= 8'h20 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_tx_sum: assert property (pready && !pwrite && paddr == OFS_TX_DELAY
		&& $past(txbuf_delay, 4) == txbuf_delay && $past(tx_slip_delay, 4) == tx_slip_delay
		&& $past(role_re_slave, 4) == role_re_slave
		|-> prdata[23:0] == TX_FIXED_DLY + txbuf_delay + (role_re_slave ? tx_slip_delay : 24'h0))
		else $error("tx path delay sum wrong");
	a_rtd_slave: assert property (pready && !pwrite && paddr == OFS_RTD && !$past(role_master, 3)
		&& !role_master |-> !prdata[31])
		else $error("round trip valid outside master role");
	a_cw_cause: assert property (cw_tx_valid |-> $past(bf_strobe) && $past(role_master))
		else $error("control byte sent without slot");
	a_req_hold: assert property ($rose(cal_ctrl[15]) |-> cal_ctrl[15] [*3])
		else $error("phase request dropped early");
	a_req_free: assert property (cal_ctrl[15] && cal_status[0] |-> ##[1:5] !cal_ctrl[15])
		else $error("phase request kept after ack");
	a_step_one: assert property (cal_ctrl[15] |-> cal_ctrl[13:0] == PHASE_STEPS)
		else $error("phase step count wrong");
endmodule
bind ldc_top ldc_chk u_chk (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
	.role_master, .role_re_slave, .txbuf_delay, .tx_slip_delay, .bf_strobe, .cw_tx_valid,
	.cal_status, .cal_ctrl);
`default_nettype wire

/* File: ldc_pcu_model.sv */
// behavioural phase control unit answering phase shift requests
`timescale 1ns/1ps
`default_nettype none
module ldc_pcu_model #(
	parameter int ACK_DLY = 3
) (
	// clock and reset
	input wire logic                       clk,
	input wire logic                       rst_b,
	// calibration link
	input wire logic [ldc_pkg::CTRL_W-1:0] cal_ctrl,
	output var logic [ldc_pkg::STAT_W-1:0] cal_status
);
	import ldc_pkg::*;
	int cnt;
	// ack after a delay, then done once the request is withdrawn
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cal_status <= '0;
			cnt <= 0;
		end else if (cal_ctrl[CTRL_REQ] && !cal_status[STS_ACK]) begin
			cal_status[STS_DONE] <= 1'b0;
			cnt <= cnt + 1;
			if (cnt == ACK_DLY) begin
				cal_status[STS_ACK] <= 1'b1;
				cnt <= 0;
			end
		end else if (!cal_ctrl[CTRL_REQ] && cal_status[STS_ACK]) begin
			cal_status <= 2'h2;
		end
	end
endmodule
`default_nettype wire

/* File: ldc_top_test.sv */
// self-checking testbench for the link delay calibration block
`timescale 1ns/1ps
`default_nettype none
module ldc_top_test;
	import ldc_pkg::*;
	localparam logic [31:0] TG [4] = '{32'h311, 32'h30f, 32'h310, 32'h311};
	localparam logic [31:0] CV [4] = '{32'h5, 32'h3, 32'h5, 32'h4};
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err, seen;
	logic role_master, role_re_slave, tx_frame_start, rx_frame_start, hf_start, bf_strobe, cw_tx_valid;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [DELAY_W-1:0] txbuf_delay, tx_slip_delay, rx_var_delay;
	logic [POS_W-1:0] hf_index;
	logic [BYTE_W-1:0] cw_rx_byte, cw_tx_byte;
	logic [STAT_W-1:0] cal_status;
	logic [CTRL_W-1:0] cal_ctrl;
	int errors, check_count;

	ldc_top #(.FRAME_CYCLES(200)) DUT (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .role_master, .role_re_slave, .txbuf_delay, .tx_slip_delay, .tx_frame_start,
		.rx_frame_start, .hf_start, .bf_strobe, .hf_index, .cw_rx_byte, .cw_tx_byte, .cw_tx_valid,
		.rx_var_delay, .cal_status, .cal_ctrl);
	ldc_pcu_model #(.ACK_DLY(3)) u_pcu (.clk, .rst_b, .cal_ctrl, .cal_status);

	initial clk = 1'b0;
	always #4 clk = ~clk;

	// ************************************************
	// tasks
	// ************************************************
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// hold the request until ready is seen at a rising edge
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ************************************************
	// sequence
	// ************************************************
	initial begin
		{psel, penable, pwrite, role_master, role_re_slave, tx_frame_start, rx_frame_start} = '0;
		{hf_start, bf_strobe, hf_index, cw_rx_byte, paddr, pwdata} = '0;
		txbuf_delay = 24'h000123;
		tx_slip_delay = 24'h000050;
		rx_var_delay = 24'h000210;
		errors = 0;
		check_count = 0;
		rst_b = 1'b0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk("reset value", rd, (i == 5) ? 32'(rx_var_delay) : 32'h0);
		end
		apb(1'b0, OFS_TX_DELAY, 32'h0);
		chk("tx delay", rd, 32'h573 - 32'h50);
		role_re_slave <= 1'b1;
		@(posedge clk);
		apb(1'b0, OFS_TX_DELAY, 32'h0);
		chk("tx delay slip", rd, 32'h573);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped err", 32'(err), 32'h1);
		role_master <= 1'b1;
		tx_frame_start <= 1'b1;
		@(posedge clk);
		tx_frame_start <= 1'b0;
		repeat (49) @(posedge clk);
		rx_frame_start <= 1'b1;
		@(posedge clk);
		rx_frame_start <= 1'b0;
		apb(1'b0, OFS_RTD, 32'h0);
		chk("round trip", rd, 32'h80000031);
		apb(1'b0, OFS_RTD, 32'h0);
		chk("round trip again", rd, 32'h80000031);
		apb(1'b1, OFS_MST_SEL, 32'h1001);
		for (int i = 0; i < 3; i++) begin
			hf_index <= 8'(8'h10 + i);
			bf_strobe <= 1'b1;
			@(posedge clk);
			bf_strobe <= 1'b0;
			#1;
			chk("cw valid", 32'(cw_tx_valid), 32'h1);
			chk("cw byte", 32'(cw_tx_byte), (32'h573 >> (8 * i)) & 32'hff);
			@(posedge clk);
		end
		role_master <= 1'b0;
		apb(1'b1, OFS_SLV_SEL, 32'h1001);
		for (int i = 0; i < 3; i++) begin
			hf_index <= 8'(8'h10 + i);
			cw_rx_byte <= 8'(8'h11 * (i + 1));
			bf_strobe <= 1'b1;
			@(posedge clk);
			bf_strobe <= 1'b0;
			@(posedge clk);
		end
		apb(1'b0, OFS_ST_STATUS, 32'h0);
		chk("measured hf", 32'(rd[23:0]), 32'h332421);
		apb(1'b0, OFS_RTD, 32'h0);
		chk("round trip valid", 32'(rd[31]), 32'h0);
		apb(1'b1, OFS_WR_MTX, 32'h100);
		apb(1'b1, OFS_SLV_SEL, 32'h0);
		apb(1'b0, OFS_ST_STATUS, 32'h0);
		chk("measured reg", 32'(rd[23:0]), 32'h310);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, OFS_ST_TARGET, TG[i]);
			apb(1'b1, OFS_ST_CTRL_A, CV[i]);
			if (i == 1) begin
				hf_start <= 1'b1;
				@(posedge clk);
				hf_start <= 1'b0;
			end
			seen = 1'b0;
			repeat (12) begin
				@(posedge clk);
				#1;
				if (cal_ctrl[CTRL_REQ] === 1'b1 && !seen) begin
					seen = 1'b1;
					chk("direction", 32'(cal_ctrl[CTRL_DIR]), 32'(i == 0));
				end
			end
			chk("request", 32'(seen), 32'(i < 2));
			repeat (30) @(posedge clk);
		end
		test_done();
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		test_done();
	end
endmodule
`default_nettype wire
